// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tcp_pkg::*;
;
   typedef struct {logic kind; logic [3:0] sel; logic [7:0] exp;} tcp_note_t;
   localparam int CTL = 0, MOD = 1, CNTW = 2, CRLO = 3, CRHI = 4, WFR = 5, WFC = 6, FIX = 7;
   localparam int CHC = 8, CWLO = 10, CWHI = 12, CVLO = 14, CVHI = 16, CFR = 18, CFC = 20;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic debugHalt = 1'b0;
   logic mark = 1'b0;
   logic [21:0] strb = '0;
   logic [7:0] timerCtlData = '0;
   logic [7:0] chanWrData = '0;
   logic [15:0] modData = '0;
   logic [1:0][4:0] chanCtlData = '0;
   logic [31:0] seed = 32'h6e611132;
   logic [31:0] rnd;
   wire logic timerCtlWrite, modWrite, counterWrite, counterReadHi, counterReadLo;
   wire logic wrapFlagRead, wrapFlagClear, fixedClkEn;
   wire logic [1:0] chanCtlWrite, chanValWrHi, chanValWrLo, chanValRdHi, chanValRdLo;
   wire logic [1:0] chanFlagRead, chanFlagClear, chanFlag, chanIrq;
   wire logic [1:0] chanPinIn, chanPinOut, chanPinOe;
   wire logic [7:0] timerCtl, counterReadData;
   wire logic wrapFlag, wrapIrq;
   wire logic [1:0][7:0] chanRdData;
   tcp_note_t noteQ[$];
   tcp_note_t cur;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   // one strobe bit per register action
   assign {chanFlagClear, chanFlagRead, chanValRdHi, chanValRdLo, chanValWrHi, chanValWrLo,
      chanCtlWrite, fixedClkEn, wrapFlagClear, wrapFlagRead, counterReadHi, counterReadLo,
      counterWrite, modWrite, timerCtlWrite} = strb;
   // result sources picked by a note
   wire logic [31:0] src8 = {timerCtl, chanRdData[1], chanRdData[0], counterReadData};
   wire logic [9:0] src1 = {chanPinOe, chanPinOut, chanIrq, chanFlag, wrapIrq, wrapFlag};

   tcp_timer dut (.sys_clk, .rstn, .timerCtlWrite, .timerCtlData, .timerCtl, .modWrite,
      .modData, .counterWrite, .counterReadHi, .counterReadLo, .counterReadData,
      .wrapFlagRead, .wrapFlagClear, .wrapFlag, .wrapIrq, .fixedClkEn, .debugHalt,
      .chanCtlWrite, .chanCtlData, .chanValWrHi, .chanValWrLo, .chanWrData, .chanValRdHi,
      .chanValRdLo, .chanRdData, .chanFlagRead, .chanFlagClear, .chanFlag, .chanIrq,
      .chanPinIn, .chanPinOut, .chanPinOe);
   tcp_pin_model pins (.sys_clk, .pinOut(chanPinOut), .pinOe(chanPinOe), .pinLevel(chanPinIn));

   // 125 MHz clock
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic results();
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic compare8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic compare1(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   // one cycle pulse on a strobe, one idle edge after it
   task automatic strobe(input int idx);
      @(posedge sys_clk);
      strb[idx] <= 1'b1;
      @(posedge sys_clk);
      strb[idx] <= 1'b0;
   endtask

   // queue an expectation and flag the monitor for one cycle
   task automatic note(input logic kind, input logic [3:0] sel, input logic [7:0] exp);
      noteQ.push_back('{kind, sel, exp});
      @(posedge sys_clk);
      mark <= 1'b1;
      @(posedge sys_clk);
      mark <= 1'b0;
   endtask

   task automatic setCtl(input logic [7:0] d);
      timerCtlData <= d;
      strobe(CTL);
   endtask

   task automatic chCtl(input int ch, input logic [4:0] d);
      chanCtlData[ch] <= d;
      strobe(CHC + ch);
   endtask

   task automatic wr16(input int ch, input logic [15:0] v);
      chanWrData <= v[7:0];
      strobe(CWLO + ch);
      chanWrData <= v[15:8];
      strobe(CWHI + ch);
   endtask

   // low byte first, high byte from the same snapshot
   task automatic rd16(input int lo, input int hi, input logic [3:0] sel, input logic [15:0] e);
      strobe(lo);
      note(1'b0, sel, e[7:0]);
      strobe(hi);
      note(1'b0, sel, e[15:8]);
   endtask

   task automatic clrFlag(input int rdIdx, input int clIdx);
      strobe(rdIdx);
      strobe(clIdx);
   endtask

   // monitor: oldest note against settled outputs
   always @(negedge sys_clk)
      if (mark === 1'b1 && noteQ.size() > 0)
      begin
         cur = noteQ.pop_front();
         if (cur.kind == 1'b0)
            compare8(src8[cur.sel*8 +: 8], cur.exp);
         else
            compare1(src1[cur.sel], cur.exp[0]);
      end

   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         results();
      end
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      note(1'b0, 4'd3, 8'h00);
      note(1'b1, 4'd8, 8'h00);
      note(1'b1, 4'd2, 8'h00);
      // fixed clock source, then clock off ignores pin pulses
      setCtl(8'h02);
      repeat (3) strobe(FIX);
      setCtl(8'h00);
      pins.clocks(3, 2);
      rd16(CRLO, CRHI, 4'd0, 16'h0003);
      // modulus 4 up counting on the external pin clock
      modData <= 16'h0004;
      strobe(MOD);
      strobe(CNTW);
      setCtl(8'h0b);
      pins.clocks(4, 2);
      note(1'b1, 4'd0, 8'h00);
      pins.clocks(1, 4);
      note(1'b1, 4'd0, 8'h01);
      note(1'b1, 4'd1, 8'h01);
      setCtl(8'h00);
      rd16(CRLO, CRHI, 4'd0, 16'h0000);
      clrFlag(WFR, WFC);
      note(1'b1, 4'd1, 8'h00);
      setCtl(8'h03);
      pins.clocks(5, 2);
      note(1'b1, 4'd0, 8'h01);
      note(1'b1, 4'd1, 8'h00);
      setCtl(8'h00);
      clrFlag(WFR, WFC);
      // centered: up to 4, turn down, wrap flag at the turn
      strobe(CNTW);
      setCtl(8'h07);
      pins.clocks(4, 2);
      note(1'b1, 4'd0, 8'h00);
      pins.clocks(1, 2);
      note(1'b1, 4'd0, 8'h01);
      pins.clocks(1, 2);
      setCtl(8'h00);
      rd16(CRLO, CRHI, 4'd0, 16'h0002);
      clrFlag(WFR, WFC);
      // bus clock source wraps within a few cycles
      strobe(CNTW);
      setCtl(8'h01);
      repeat (12) @(posedge sys_clk);
      note(1'b1, 4'd0, 8'h01);
      setCtl(8'h00);
      clrFlag(WFR, WFC);
      // capture on rising, falling and both edges of pin 1
      for (int e = 1; e < 4; e++)
      begin
         chCtl(1, 5'h10 | 5'(e));
         strobe(CNTW);
         setCtl(8'h03);
         pins.clocks(1, 2);
         pins.eventEdge(1'b1);
         pins.clocks(2, 2);
         pins.eventEdge(1'b0);
         setCtl(8'h00);
         note(1'b1, 4'd3, 8'h01);
         note(1'b1, 4'd5, 8'h01);
         rd16(CVLO + 1, CVHI + 1, 4'd2, (e == 1) ? 16'h0001 : 16'h0003);
         clrFlag(CFR + 1, CFC + 1);
      end
      // random writes in capture mode are dropped
      rnd = xorshift();
      wr16(1, rnd[15:0]);
      rd16(CVLO + 1, CVHI + 1, 4'd2, 16'h0003);
      // debug halt: counter frozen at 1, capture still stores it
      strobe(CNTW);
      setCtl(8'h03);
      pins.clocks(1, 2);
      debugHalt <= 1'b1;
      pins.clocks(2, 2);
      pins.eventEdge(1'b1);
      note(1'b1, 4'd3, 8'h01);
      debugHalt <= 1'b0;
      setCtl(8'h00);
      rd16(CVLO + 1, CVHI + 1, 4'd2, 16'h0001);
      // compare at 3: set, clear, toggle
      for (int i = 0; i < 3; i++)
      begin
         chCtl(1, 5'h04 | 5'(3 - i));
         if (i == 0)
            wr16(1, 16'h0003);
         strobe(CNTW);
         setCtl(8'h03);
         pins.clocks(3, 2);
         setCtl(8'h00);
         note(1'b1, 4'd7, (i == 1) ? 8'h00 : 8'h01);
         note(1'b1, 4'd9, 8'h01);
      end
      // edge pwm, high-true, modulus 4, value 2
      chCtl(1, 5'h0a);
      wr16(1, 16'h0002);
      strobe(CNTW);
      setCtl(8'h03);
      pins.clocks(5, 2);
      note(1'b1, 4'd7, 8'h01);
      pins.clocks(2, 2);
      note(1'b1, 4'd7, 8'h00);
      wr16(1, 16'h0005);
      pins.clocks(5, 2);
      note(1'b1, 4'd7, 8'h01);
      setCtl(8'h00);
      results();
   end
endmodule
`default_nettype wire

// *** tcp_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_channel
   import tcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   tcp_link_if.chan link,
   input wire logic ctlWrite,
   input wire logic [4:0] ctlData,
   input wire logic wrHi,
   input wire logic wrLo,
   input wire logic [7:0] wrData,
   input wire logic rdHi,
   input wire logic rdLo,
   output logic [7:0] rdData,
   input wire logic flagRead,
   input wire logic flagClear,
   output logic flag,
   output logic irq,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   logic [4:0] ctl;
   logic [15:0] value;
   logic [7:0] bufHi;
   logic [7:0] bufLo;
   logic gotHi;
   logic gotLo;
   logic pending;
   logic [15:0] pendVal;
   logic rdLatched;
   logic [15:0] rdBuf;
   logic flagArm;
   logic s1;
   logic s2;
   logic s3;
   logic lvl;

   // mode decode
   wire [1:0] edgeSel = ctl[`TCP_CHC_EDGE];
   wire [1:0] modeSel = ctl[`TCP_CHC_MODE];
   wire tcp_func_t func = link.centered ? TCP_F_CPWM :
      modeSel[1] ? TCP_F_EPWM : tcp_func_t'(modeSel);
   wire isIc = (func == TCP_F_IC);
   wire isOc = (func == TCP_F_OC);
   wire isEp = (func == TCP_F_EPWM);
   wire isCp = (func == TCP_F_CPWM);

   // pin edges once the second and third stage agree
   wire chg = (s2 == s3) && (s3 != lvl);
   wire capEv = isIc && chg && (s3 ? edgeSel[0] : edgeSel[1]);
   wire match = link.stepped && !isIc && (link.count == value);
   wire event_ = capEv || match;

   // value write buffering
   wire wrOk = (wrHi || wrLo) && !isIc;
   wire [15:0] wrBuf = {wrHi ? wrData : bufHi, wrLo ? wrData : bufLo};
   wire [15:0] direct = {wrHi ? wrData : value[15:8], wrLo ? wrData : value[7:0]};
   wire bothIn = wrOk && !link.halt && (gotHi || wrHi) && (gotLo || wrLo);
   wire applyPend = pending && (isOc ? link.tick : link.termNext);
   wire [15:0] next_value = capEv ? link.count :
      (wrOk && link.halt) ? direct :
      (bothIn && link.clkOff) ? wrBuf :
      applyPend ? pendVal : value;

   // read coherency
   wire rd = rdHi || rdLo;
   wire [15:0] rdSrc = (rdLatched && !link.halt) ? rdBuf : value;

   // pin level per mode
   wire ocLvl = edgeSel[1] ? edgeSel[0] : (edgeSel[0] ? !pinOut : pinOut);
   wire next_pin = (isOc && match) ? ocLvl :
      (isEp && match) ? edgeSel[0] :
      (isEp && link.wrapped) ? !edgeSel[0] :
      (isCp && match) ? (link.countUp ? edgeSel[0] : !edgeSel[0]) : pinOut;

   // two-step flag clear, new event wins
   wire next_flag = event_ || (flag && !(flagClear && flagArm));
   wire next_arm = !event_ && ((flagRead && flag) || (flagArm && !flagClear));
   wire [4:0] next_ctl = ctlWrite ? ctlData : ctl;

   // control, flag, pin and synchroniser
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl <= `TCP_CHC_RST;
         flag <= 1'b0;
         flagArm <= 1'b0;
         irq <= 1'b0;
         pinOut <= 1'b0;
         pinOe <= 1'b0;
         {s1, s2, s3, lvl} <= 4'h0;
      end
      else
      begin
         ctl <= next_ctl;
         flag <= next_flag;
         flagArm <= next_arm;
         irq <= next_flag && next_ctl[`TCP_CHC_IE];
         pinOut <= next_pin;
         pinOe <= (edgeSel != `TCP_EL_OFF) && !isIc;
         {s1, s2, s3} <= {pinIn, s1, s2};
         lvl <= (s2 == s3) ? s3 : lvl;
      end
   end

   // value register and write buffer
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         value <= `TCP_CNT_ZERO;
         {bufHi, bufLo, pendVal} <= 32'h0000_0000;
         {gotHi, gotLo, pending} <= 3'h0;
      end
      else
      begin
         value <= next_value;
         if (ctlWrite)
            {gotHi, gotLo, pending} <= 3'h0;
         else if (bothIn)
         begin
            {gotHi, gotLo} <= 2'h0;
            pending <= !link.clkOff;
            pendVal <= wrBuf;
         end
         else if (wrOk && !link.halt)
         begin
            {bufHi, bufLo} <= wrBuf;
            gotHi <= gotHi || wrHi;
            gotLo <= gotLo || wrLo;
         end
         else if (applyPend)
            pending <= 1'b0;
      end
   end

   // coherent byte reads
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdLatched <= 1'b0;
         rdBuf <= `TCP_CNT_ZERO;
         rdData <= 8'h00;
      end
      else
      begin
         if (rd)
            rdData <= rdHi ? rdSrc[15:8] : rdSrc[7:0];
         if (ctlWrite)
            rdLatched <= 1'b0;
         else if (rd && !link.halt)
         begin
            rdLatched <= !rdLatched;
            rdBuf <= rdLatched ? rdBuf : value;
         end
      end
   end

   AST_CAPTURE: assert property (capEv |=> value == $past(link.count) && flag)
      else $error("capture did not store count");
   AST_IC_RO: assert property (isIc && wrOk == 1'b0 && (wrHi || wrLo) && !capEv |=> $stable(value))
      else $error("write changed capture value");
   AST_OC_SET: assert property (isOc && match && edgeSel == `TCP_EL_SET |=> pinOut)
      else $error("set on match failed");
endmodule
`default_nettype wire

// *** tcp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// counter state shared by the timer core and its channels
interface tcp_link_if;
   logic [15:0] count;
   logic stepped;
   logic wrapped;
   logic countUp;
   logic clkOff;
   logic centered;
   logic halt;
   logic tick;
   logic termNext;
   modport timer(output count, stepped, wrapped, countUp, clkOff, centered, halt, tick, termNext);
   modport chan(input count, stepped, wrapped, countUp, clkOff, centered, halt, tick, termNext);
endinterface
`default_nettype wire

// *** tcp_map.svh ***
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
// clock source selector codes
`define TCP_CLK_OFF 2'b00
`define TCP_CLK_BUS 2'b01
`define TCP_CLK_FIX 2'b10
`define TCP_CLK_EXT 2'b11
// counter values
`define TCP_CNT_ZERO 16'h0000
`define TCP_CNT_ONE 16'h0001
`define TCP_CNT_TOP 16'hffff
// channel count
`define TCP_NUM_CH 2
// timer control fields and reset value
`define TCP_CTL_CLK 1:0
`define TCP_CTL_CPWM 2
`define TCP_CTL_WIE 3
`define TCP_CTL_PSC 6:4
`define TCP_CTL_RST 8'h00
// channel control fields and reset value
`define TCP_CHC_EDGE 1:0
`define TCP_CHC_MODE 3:2
`define TCP_CHC_IE 4
`define TCP_CHC_RST 5'h00
// edge/level codes
`define TCP_EL_OFF 2'b00
`define TCP_EL_TOGGLE 2'b01
`define TCP_EL_SET 2'b11
`endif

// *** tcp_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side of the two channel pins: counting clock on pin 0, events on pin 1
module tcp_pin_model
   import tcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [1:0] pinOut,
   input wire logic [1:0] pinOe,
   output logic [1:0] pinLevel
);
   logic [1:0] drive = 2'b00;
   // wire level: the design wins wherever it drives
   assign pinLevel = (pinOe & pinOut) | (~pinOe & drive);
   // n clock pulses; half of at least 2 keeps a quarter of bus rate or slower
   task automatic clocks(input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge sys_clk);
         drive[0] <= 1'b1;
         repeat (half) @(posedge sys_clk);
         drive[0] <= 1'b0;
      end
      // clock stands low outside a burst; let the synchronizer drain
      repeat (8) @(posedge sys_clk);
   endtask
   // one level change on the event pin
   task automatic eventEdge(input logic lvl);
      @(posedge sys_clk);
      drive[1] <= lvl;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// *** tcp_pkg.sv ***
`include "tcp_map.svh"
package tcp_pkg;
   // clock source to the prescaler
   typedef enum logic [1:0] {
      TCP_CLK_OFF = `TCP_CLK_OFF,
      TCP_CLK_BUS = `TCP_CLK_BUS,
      TCP_CLK_FIX = `TCP_CLK_FIX,
      TCP_CLK_EXT = `TCP_CLK_EXT
   } tcp_clk_t;
   // channel function
   typedef enum logic [1:0] {
      TCP_F_IC = 2'b00,
      TCP_F_OC = 2'b01,
      TCP_F_EPWM = 2'b10,
      TCP_F_CPWM = 2'b11
   } tcp_func_t;
endpackage

// *** tcp_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_timer
   import tcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic timerCtlWrite,
   input wire logic [7:0] timerCtlData,
   output logic [7:0] timerCtl,
   input wire logic modWrite,
   input wire logic [15:0] modData,
   input wire logic counterWrite,
   input wire logic counterReadHi,
   input wire logic counterReadLo,
   output logic [7:0] counterReadData,
   input wire logic wrapFlagRead,
   input wire logic wrapFlagClear,
   output logic wrapFlag,
   output logic wrapIrq,
   input wire logic fixedClkEn,
   input wire logic debugHalt,
   input wire logic [`TCP_NUM_CH-1:0] chanCtlWrite,
   input wire logic [`TCP_NUM_CH-1:0][4:0] chanCtlData,
   input wire logic [`TCP_NUM_CH-1:0] chanValWrHi,
   input wire logic [`TCP_NUM_CH-1:0] chanValWrLo,
   input wire logic [7:0] chanWrData,
   input wire logic [`TCP_NUM_CH-1:0] chanValRdHi,
   input wire logic [`TCP_NUM_CH-1:0] chanValRdLo,
   output logic [`TCP_NUM_CH-1:0][7:0] chanRdData,
   input wire logic [`TCP_NUM_CH-1:0] chanFlagRead,
   input wire logic [`TCP_NUM_CH-1:0] chanFlagClear,
   output logic [`TCP_NUM_CH-1:0] chanFlag,
   output logic [`TCP_NUM_CH-1:0] chanIrq,
   input wire logic [`TCP_NUM_CH-1:0] chanPinIn,
   output logic [`TCP_NUM_CH-1:0] chanPinOut,
   output logic [`TCP_NUM_CH-1:0] chanPinOe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   logic [15:0] modulus;
   logic [15:0] count;
   logic countUp;
   logic stepped;
   logic wrapped;
   logic wrapArm;
   logic [6:0] pscCnt;
   logic cntLatched;
   logic [15:0] cntBuf;
   logic extS1;
   logic extS2;
   logic extS3;
   logic extLvl;
   wire srcEn;
   wire tick;

   // control fields
   wire tcp_clk_t clkSel = tcp_clk_t'(timerCtl[`TCP_CTL_CLK]);
   wire centered = timerCtl[`TCP_CTL_CPWM];
   wire [2:0] pscSel = timerCtl[`TCP_CTL_PSC];
   wire [7:0] next_ctl = timerCtlWrite ? timerCtlData : timerCtl;

   // external clock from channel 0 pin, edge once stages two and three agree
   wire extRise = (extS2 == extS3) && extS3 && !extLvl;

   // clock source choice
   assign srcEn = (clkSel == TCP_CLK_BUS) ? 1'b1 :
      (clkSel == TCP_CLK_FIX) ? fixedClkEn :
      (clkSel == TCP_CLK_EXT) ? extRise : 1'b0;

   // power-of-two prescaler, frozen in debug halt
   wire [6:0] pscMask = 7'((8'h01 << pscSel) - 8'h01);
   assign tick = srcEn && !debugHalt && ((pscCnt & pscMask) == pscMask);

   // terminal count and next count
   wire [15:0] term = (modulus == `TCP_CNT_ZERO) ? `TCP_CNT_TOP : modulus;
   wire atTerm = (count == term);
   wire atZero = (count == `TCP_CNT_ZERO);
   wire [15:0] cntInc = count + `TCP_CNT_ONE;
   wire [15:0] cntDec = count - `TCP_CNT_ONE;
   wire turnDown = centered && countUp && atTerm;
   wire turnUp = centered && !countUp && atZero;
   wire goDown = turnDown || (centered && !countUp && !atZero);
   wire [15:0] stepVal = (!centered && atTerm) ? `TCP_CNT_ZERO :
      goDown ? cntDec : cntInc;
   wire next_up = !centered || turnUp || (countUp && !turnDown);
   wire wrapEv = tick && !counterWrite && (centered ? turnDown : atTerm);
   wire termNext = tick && (!centered || countUp) && (cntInc == term);

   // wrap flag: two-step clear, a new wrap wins
   wire wrapClr = wrapFlagClear && wrapArm;
   wire next_wrapFlag = wrapEv || (wrapFlag && !wrapClr);
   wire next_wrapArm = !wrapEv && ((wrapFlagRead && wrapFlag) || (wrapArm && !wrapFlagClear));

   // counter byte read coherency
   wire cntRd = counterReadHi || counterReadLo;
   wire [15:0] cntSrc = cntLatched ? cntBuf : count;
   wire [7:0] next_cntRd = counterReadHi ? cntSrc[15:8] : cntSrc[7:0];

   // control and modulus registers
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timerCtl <= `TCP_CTL_RST;
         modulus <= `TCP_CNT_ZERO;
      end
      else
      begin
         timerCtl <= next_ctl;
         if (modWrite)
            modulus <= modData;
      end
   end

   // external pin synchroniser
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         {extS1, extS2, extS3, extLvl} <= 4'h0;
      end
      else
      begin
         {extS1, extS2, extS3} <= {chanPinIn[0], extS1, extS2};
         extLvl <= (extS2 == extS3) ? extS3 : extLvl;
      end
   end

   // prescaler
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         pscCnt <= 7'h00;
      else if (srcEn && !debugHalt)
         pscCnt <= pscCnt + 7'h01;
   end

   // main counter
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count <= `TCP_CNT_ZERO;
         countUp <= 1'b1;
         stepped <= 1'b0;
         wrapped <= 1'b0;
      end
      else
      begin
         stepped <= tick && !counterWrite;
         wrapped <= wrapEv;
         if (counterWrite)
         begin
            count <= `TCP_CNT_ZERO;
            countUp <= 1'b1;
         end
         else if (tick)
         begin
            count <= stepVal;
            countUp <= next_up;
         end
      end
   end

   // wrap flag and its level request
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wrapFlag <= 1'b0;
         wrapArm <= 1'b0;
         wrapIrq <= 1'b0;
      end
      else
      begin
         wrapFlag <= next_wrapFlag;
         wrapArm <= next_wrapArm;
         wrapIrq <= next_wrapFlag && next_ctl[`TCP_CTL_WIE];
      end
   end

   // counter reads
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cntLatched <= 1'b0;
         cntBuf <= `TCP_CNT_ZERO;
         counterReadData <= 8'h00;
      end
      else
      begin
         if (cntRd)
            counterReadData <= next_cntRd;
         if (counterWrite)
            cntLatched <= 1'b0;
         else if (cntRd)
         begin
            cntLatched <= !cntLatched;
            cntBuf <= cntLatched ? cntBuf : count;
         end
      end
   end

   // shared counter view for the channels
   tcp_link_if link();
   assign link.count = count;
   assign link.stepped = stepped;
   assign link.wrapped = wrapped;
   assign link.countUp = countUp;
   assign link.clkOff = (clkSel == TCP_CLK_OFF);
   assign link.centered = centered;
   assign link.halt = debugHalt;
   assign link.tick = tick;
   assign link.termNext = termNext;

   // one channel per pin
   genvar gi;
   generate
      for (gi = 0; gi < `TCP_NUM_CH; gi++)
      begin : g_ch
         tcp_channel u_ch (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .link(link),
            .ctlWrite(chanCtlWrite[gi]),
            .ctlData(chanCtlData[gi]),
            .wrHi(chanValWrHi[gi]),
            .wrLo(chanValWrLo[gi]),
            .wrData(chanWrData),
            .rdHi(chanValRdHi[gi]),
            .rdLo(chanValRdLo[gi]),
            .rdData(chanRdData[gi]),
            .flagRead(chanFlagRead[gi]),
            .flagClear(chanFlagClear[gi]),
            .flag(chanFlag[gi]),
            .irq(chanIrq[gi]),
            .pinIn(chanPinIn[gi]),
            .pinOut(chanPinOut[gi]),
            .pinOe(chanPinOe[gi])
         );
      end
   endgenerate

   // checks on the counter
   AST_HALT_HOLD: assert property (clkSel == TCP_CLK_OFF && !counterWrite |=> $stable(count))
      else $error("count moved with clock off");
   AST_ONE_STEP: assert property (tick && !counterWrite && !centered && !atTerm
      |=> count == $past(count) + 16'h0001)
      else $error("count did not step by one");
   AST_FREE_WRAP: assert property (tick && !counterWrite && !centered && modulus == 16'h0000
      && count == 16'hffff |=> count == 16'h0000 && wrapFlag)
      else $error("free run wrap wrong");
   AST_MOD_WRAP: assert property (tick && !counterWrite && !centered && modulus != 16'h0000
      && count == modulus |=> count == 16'h0000 && wrapFlag)
      else $error("modulus wrap wrong");
   AST_TURN: assert property (turnDown && tick && !counterWrite
      |=> !countUp && wrapFlag && count == $past(count) - 16'h0001)
      else $error("centered turn wrong");
   AST_IRQ_LEVEL: assert property (wrapIrq == (wrapFlag && timerCtl[`TCP_CTL_WIE]))
      else $error("wrap request not level");
   AST_CNT_CLEAR: assert property (counterWrite |=> count == 16'h0000 && !cntLatched)
      else $error("counter write did not clear");

   // main scenarios
   CVR_WRAP: cover property (wrapEv && !centered);
   CVR_TURN: cover property (wrapEv && centered);
   CVR_EXT: cover property (clkSel == TCP_CLK_EXT && tick);
   CVR_CLR_LATCH: cover property (counterWrite && cntLatched);
endmodule
`default_nettype wire
